// file: burst_sram_defines.svh
// constants for the burst sram write-control block
`ifndef BURST_SRAM_DEFINES_SVH
`define BURST_SRAM_DEFINES_SVH
`define LANE_BITS 9
`define BURST_BITS 2
`define SLEEP_CYCLES_NS 20
`define CLK_PERIOD_NS 10
`define SLEEP_CYCLES ((`SLEEP_CYCLES_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// file: burst_sram_pkg.sv
// types for the burst sram write-control block
package burst_sram_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE} cycle_type;
endpackage

// file: lane_write_buffer.sv
// two-entry buffer carrying write beats to the storage array
`timescale 1ns/1ns
module lane_write_buffer #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem_r [2];
  logic wptr_r;
  logic rptr_r;
  logic [1:0] count_r;
  logic push;
  logic pop;

  // a zero-width beat has nothing to carry
  initial begin
    if (WIDTH < 1) begin
      $error("WIDTH must be at least 1");
    end
  end

  // honest full and empty flags
  assign in_ready = (count_r != 2'h2);
  assign out_valid = (count_r != 2'h0);
  assign out_data = mem_r[rptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage is written only on accepted beats
  always_ff @(posedge clk_sys) begin
    if (push) begin
      mem_r[wptr_r] <= in_data;
    end
  end

  // pointers and fill level
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wptr_r <= 1'b0;
      rptr_r <= 1'b0;
      count_r <= 2'h0;
    end else begin
      if (push) begin
        wptr_r <= ~wptr_r;
      end
      if (pop) begin
        rptr_r <= ~rptr_r;
      end
      count_r <= count_r + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule

// file: burst_sram_ctrl.sv
// synchronous burst sram bus decoding with byte-lane writes
//
// Summary of operation
// - begin-burst write loads external address when selected, load, strobe and a lane low.
// - advance high continues burst, ignores selects and strobe, writes selected lanes.
// - begin write with all lanes high is an abort; no address, bus tri-stated.
// - continue write with all lanes high still steps address, writes nothing.
// - clock qualify high makes the edge ignored; burst state held unless sleeping, and a buffered write beat still drains into the array.
// - four-lane write with all selects high leaves memory unchanged; strobe high reads.
// - each of four lane selects writes its byte plus parity; lane d is top.
// - any combination of lane selects writes exactly those lanes.
// - two-lane organisation writes each selected byte and parity.
// - eight-lane organisation writes each selected lane; all or none as selected.
// - read begins with load low, strobe high; output when enable active.
// - burst counter over low two bits, interleaved or linear by order pin.
// - write data latched on the following edge; drivers off during data phase.
`timescale 1ns/1ns
`include "burst_sram_defines.svh"
module burst_sram_ctrl
  import burst_sram_pkg::*;
#(
  parameter int LANES = 4,
  parameter int ADDR_W = 8
) (
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic clock_qualify_n,
  input wire logic chip_select_n,
  input wire logic burst_advance_or_load,
  input wire logic write_strobe_n,
  input wire logic [LANES-1:0] byte_lane_select_n,
  input wire logic output_enable_n,
  input wire logic sleep_request,
  input wire logic burst_order,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [LANES*(`LANE_BITS)-1:0] data_in,
  output logic [LANES*(`LANE_BITS)-1:0] data_out,
  output logic [LANES*(`LANE_BITS)-1:0] data_oe,
  output logic asleep
);
  localparam int LB = `LANE_BITS;
  localparam int DW = LANES * LB;
  localparam int DEPTH = 1 << ADDR_W;

  initial begin
    if (LANES != 2 && LANES != 4 && LANES != 8) begin
      $error("LANES must be 2, 4 or 8");
    end
    // the burst counter owns the low two bits, so a base field above them is needed
    if (ADDR_W < 3 || ADDR_W > 12) begin
      $error("ADDR_W must be 3..12");
    end
  end

  // next burst address over the low two bits
  function automatic logic [1:0] burst_step(input logic [1:0] start, input logic [1:0] cnt,
                                            input logic interleave);
    burst_step = interleave ? (start ^ cnt) : 2'(start + cnt);
  endfunction

  // async pins pass two flops before use
  logic sleep_s1_r, sleep_s2_r, oe_s1_r, oe_s2_r, order_s1_r, order_s2_r;
  always_ff @(posedge clk_sys) begin
    sleep_s1_r <= sleep_request;
    sleep_s2_r <= sleep_s1_r;
    oe_s1_r <= output_enable_n;
    oe_s2_r <= oe_s1_r;
    order_s1_r <= burst_order;
    order_s2_r <= order_s1_r;
  end

  // command decode
  logic any_lane;
  logic begin_wr, begin_rd, cont, deselect;
  logic sleeping;
  assign sleeping = sleep_s2_r;
  assign any_lane = ~&byte_lane_select_n;
  always_comb begin
    begin_wr = 1'b0;
    begin_rd = 1'b0;
    cont = 1'b0;
    deselect = 1'b0;
    if (!sleeping && !clock_qualify_n) begin
      if (burst_advance_or_load) begin
        cont = 1'b1;
      end else if (chip_select_n) begin
        deselect = 1'b1;
      end else if (!write_strobe_n) begin
        begin_wr = 1'b1;
      end else begin
        begin_rd = 1'b1;
      end
    end
  end

  // burst state: base address, step count and current cycle kind
  cycle_type state_r;
  logic [ADDR_W-1:0] base_r;
  logic [1:0] cnt_r;
  logic [ADDR_W-1:0] cur_addr;
  assign cur_addr = {base_r[ADDR_W-1:2], burst_step(base_r[1:0], cnt_r, order_s2_r)};

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      base_r <= '0;
      cnt_r <= 2'h0;
    end else if (sleeping) begin
      state_r <= ST_IDLE;
    end else if (!clock_qualify_n) begin
      if (begin_wr && any_lane) begin
        state_r <= ST_WRITE;
        base_r <= addr;
        cnt_r <= 2'h0;
      end else if (begin_wr) begin
        state_r <= ST_WRITE; // abort: address unused
      end else if (begin_rd) begin
        state_r <= ST_READ;
        base_r <= addr;
        cnt_r <= 2'h0;
      end else if (cont && state_r != ST_IDLE) begin
        cnt_r <= cnt_r + 2'h1; // steps even with no lanes
      end else if (deselect) begin
        state_r <= ST_IDLE;
      end
    end
  end

  // command-cycle pipeline; data follows one edge later
  logic wr_pend_r, rd_pend_r;
  logic [LANES-1:0] lanes_r;
  logic [ADDR_W-1:0] pend_addr_r;
  logic do_write, do_read;
  assign do_write = (begin_wr && any_lane) || (cont && state_r == ST_WRITE && any_lane);
  assign do_read = begin_rd || (cont && state_r == ST_READ);

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      lanes_r <= '0;
      pend_addr_r <= '0;
    end else if (sleeping) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
    end else if (!clock_qualify_n) begin
      wr_pend_r <= do_write;
      rd_pend_r <= do_read;
      lanes_r <= ~byte_lane_select_n;
      pend_addr_r <= (begin_wr || begin_rd) ? addr
                     : {base_r[ADDR_W-1:2],
                        burst_step(base_r[1:0], 2'(cnt_r + 2'h1), order_s2_r)};
    end
  end

  // write beats pass a two-entry buffer to the array
  logic buf_in_ready, buf_out_valid;
  logic [ADDR_W+LANES+DW-1:0] buf_out_data;
  logic push;
  assign push = wr_pend_r && !clock_qualify_n && !sleeping;
  lane_write_buffer #(.WIDTH(ADDR_W + LANES + DW)) u_wbuf (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .in_valid(push),
    .in_ready(buf_in_ready),
    .in_data({pend_addr_r, lanes_r, data_in}),
    .out_valid(buf_out_valid),
    .out_ready(1'b1),
    .out_data(buf_out_data)
  );

  // storage: one bank per lane, so that every bank has a single writer
  logic [ADDR_W-1:0] wa;
  logic [LANES-1:0] wl;
  logic [DW-1:0] wd;
  logic [ADDR_W-1:0] ra;
  wire logic [DW-1:0] rd_word;
  assign wa = buf_out_data[ADDR_W+LANES+DW-1:LANES+DW];
  assign wl = buf_out_data[LANES+DW-1:DW];
  assign wd = buf_out_data[DW-1:0];
  assign ra = rd_pend_r ? pend_addr_r : cur_addr;
  genvar g;
  generate
    for (g = 0; g < LANES; g++) begin : g_lane
      logic [LB-1:0] bank_r [DEPTH];
      // lane g holds byte g and its parity, top lane highest
      always_ff @(posedge clk_sys) begin
        if (buf_out_valid && wl[g]) begin
          bank_r[wa] <= wd[g*LB +: LB];
        end
      end
      assign rd_word[g*LB +: LB] = bank_r[ra];
    end
  endgenerate

  // read data and bus enables; writes always keep the bus off
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      data_out <= '0;
      data_oe <= '0;
    end else if (sleeping || wr_pend_r ||
                 (!clock_qualify_n && (begin_wr || (cont && state_r == ST_WRITE)))) begin
      data_oe <= '0;
    end else if (!clock_qualify_n) begin
      data_out <= rd_word;
      data_oe <= {DW{rd_pend_r && !oe_s2_r}};
    end
  end

  // sleep status
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      asleep <= 1'b0;
    end else begin
      asleep <= sleeping;
    end
  end

  AST_SLEEP_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
    sleeping |=> data_oe == '0) else $error("bus driven in sleep");
  AST_WRITE_OFF: assert property (@(posedge clk_sys) disable iff (!nrst)
    wr_pend_r |=> data_oe == '0) else $error("bus driven in write data");
  AST_STALL_HOLD: assert property (@(posedge clk_sys) disable iff (!nrst)
    (clock_qualify_n && !sleeping) |=> $stable(cnt_r) && $stable(base_r))
    else $error("stall changed state");
  AST_BEGIN_ADDR: assert property (@(posedge clk_sys) disable iff (!nrst)
    (begin_wr && any_lane) |=> base_r == $past(addr) && cnt_r == 2'h0)
    else $error("write begin lost address");
  AST_ABORT: assert property (@(posedge clk_sys) disable iff (!nrst)
    (begin_wr && !any_lane) |=> !wr_pend_r && $stable(base_r))
    else $error("abort wrote");
  AST_STEP: assert property (@(posedge clk_sys) disable iff (!nrst)
    (cont && state_r == ST_WRITE && !any_lane) |=> cnt_r == 2'($past(cnt_r) + 2'h1) && !wr_pend_r)
    else $error("abort continue failed");
  AST_LANES: assert property (@(posedge clk_sys) disable iff (!nrst)
    do_write |=> lanes_r == ~$past(byte_lane_select_n))
    else $error("lane mask wrong");
  AST_READ_START: assert property (@(posedge clk_sys) disable iff (!nrst)
    begin_rd |=> state_r == ST_READ && rd_pend_r)
    else $error("read begin missed");
  // a refused beat would silently drop write data
  AST_BUF_ROOM: assert property (@(posedge clk_sys) disable iff (!nrst)
    push |-> buf_in_ready)
    else $error("write beat refused by buffer");
  AST_SLEEP_IDLE: assert property (@(posedge clk_sys) disable iff (!nrst)
    sleeping |=> state_r == ST_IDLE && !wr_pend_r && !rd_pend_r)
    else $error("access left pending in sleep");
endmodule

// file: ctrl_model.sv
// behavioural memory controller that drives the burst sram bus
`timescale 1ns/1ns
`include "burst_sram_defines.svh"
module ctrl_model #(
  parameter int LANES = 4,
  parameter int ADDR_W = 4
) (
  input wire logic clk_sys,
  output logic clock_qualify_n,
  output logic chip_select_n,
  output logic burst_advance_or_load,
  output logic write_strobe_n,
  output logic [LANES-1:0] byte_lane_select_n,
  output logic sleep_request,
  output logic [ADDR_W-1:0] addr,
  output logic [LANES*(`LANE_BITS)-1:0] data_in
);
  // one bus cycle; a bus without write data shows the inverse of its last value
  task automatic put(input logic cq, cs, adv, we, input logic [LANES-1:0] bl,
    input logic [ADDR_W-1:0] a, input logic dv, input logic [LANES*(`LANE_BITS)-1:0] d);
    clock_qualify_n = cq;
    chip_select_n = cs;
    burst_advance_or_load = adv;
    write_strobe_n = we;
    byte_lane_select_n = bl;
    addr = a;
    data_in = dv ? d : ~data_in;
  endtask
  // deselect cycle
  task automatic idle();
    put(1'b0, 1'b1, 1'b0, 1'b1, '1, '0, 1'b0, '0);
  endtask
  // deselect a cycle ahead so that no access is pending on sleep entry
  task automatic doze(input logic on);
    @(negedge clk_sys) idle();
    @(negedge clk_sys) sleep_request = on;
  endtask
  // defined bus from time zero
  initial begin
    sleep_request = 1'b0;
    data_in = '0;
    idle();
  end
endmodule

// file: tb_burst_sram_ctrl.sv
// self-checking bench for the burst sram write-control block
`timescale 1ns/1ns
`include "burst_sram_defines.svh"
module tb_burst_sram_ctrl;
  localparam int L = 4;
  localparam int AW = 4;
  localparam int DW = L * `LANE_BITS;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic output_enable_n = 1'b0;
  logic burst_order = 1'b1;
  logic cq_n, cs_n, adv, we_n, zz;
  logic [L-1:0] bl_n;
  logic [AW-1:0] addr;
  logic [DW-1:0] data_in, data_out, data_oe;
  logic asleep;
  logic [DW-1:0] mem_exp [16];
  logic [L-1:0] m [4];
  int error_cnt = 0;
  int tests_run = 0;
  // free-running system clock
  always #5 clk_sys = ~clk_sys;
  ctrl_model #(.LANES(L), .ADDR_W(AW)) u_ctrl_model (.clk_sys(clk_sys),
    .clock_qualify_n(cq_n), .chip_select_n(cs_n), .burst_advance_or_load(adv),
    .write_strobe_n(we_n), .byte_lane_select_n(bl_n), .sleep_request(zz),
    .addr(addr), .data_in(data_in));
  burst_sram_ctrl #(.LANES(L), .ADDR_W(AW)) u_burst_sram_ctrl (.clk_sys(clk_sys),
    .nrst(nrst), .clock_qualify_n(cq_n), .chip_select_n(cs_n),
    .burst_advance_or_load(adv), .write_strobe_n(we_n), .byte_lane_select_n(bl_n),
    .output_enable_n(output_enable_n), .sleep_request(zz), .burst_order(burst_order),
    .addr(addr), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .asleep(asleep));
  task automatic check_word(input string what, input logic [DW-1:0] e, input logic [DW-1:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %h got %h", what, e, g);
    end
  endtask
  task automatic check_bit(input string what, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("wrong value %s exp %b got %b", what, e, g);
    end
  endtask
  // burst sequence on the low two address bits
  function automatic logic [AW-1:0] baddr(input logic [AW-1:0] a, input int k, input logic il);
    logic [1:0] lo;
    lo = il ? (a[1:0] ^ 2'(k)) : (a[1:0] + 2'(k));
    return {a[AW-1:2], lo};
  endfunction
  task automatic idle(input int n);
    repeat (n) @(negedge clk_sys) u_ctrl_model.idle();
  endtask
  // four-beat write; stall edges carry junk that must be ignored entirely
  task automatic write_burst(input logic [AW-1:0] a, input logic stall);
    logic [DW-1:0] d [4];
    for (int k = 0; k < 4; k++) d[k] = DW'({$urandom(), $urandom()});
    for (int k = 0; k < 5; k++) begin
      if (stall && $urandom_range(1) == 1) @(negedge clk_sys) u_ctrl_model.put(1'b1,
        1'($urandom), 1'($urandom), 1'($urandom), L'($urandom), AW'($urandom), 1'b1,
        DW'({$urandom(), $urandom()}));
      if (k == 0) @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'b0, 1'b0, 1'b0, m[0], a,
        1'b0, '0);
      else if (k < 4) @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'($urandom), 1'b1,
        1'($urandom), m[k], AW'($urandom), 1'b1, d[k-1]);
      else @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'b1, 1'b0, 1'b1, '1, a, 1'b1, d[3]);
      @(posedge clk_sys);
      #1 check_bit("drive in write", 1'b0, |data_oe);
    end
    // lanes not selected keep their old contents
    for (int k = 0; k < 4; k++)
      for (int g = 0; g < L; g++)
        if (!m[k][g]) mem_exp[baddr(a, k, burst_order)][g*9 +: 9] = d[k][g*9 +: 9];
  endtask
  // four-beat read; data stands one qualified edge after each command
  task automatic read_burst(input logic [AW-1:0] a);
    logic [DW-1:0] e;
    for (int k = 0; k < 6; k++) begin
      if (k == 0) @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'b0, 1'b0, 1'b1, L'($urandom),
        a, 1'b0, '0);
      else if (k < 4) @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'($urandom), 1'b1, 1'b1,
        L'($urandom), AW'($urandom), 1'b0, '0);
      else @(negedge clk_sys) u_ctrl_model.idle();
      @(posedge clk_sys);
      #1;
      if (k >= 1 && k <= 4) check_word("drive", {DW{!output_enable_n}}, data_oe);
      if (k >= 1 && k <= 4 && !output_enable_n) begin
        e = mem_exp[baddr(a, k - 1, burst_order)];
        check_word("read data", e, data_out);
      end
      if (k == 5) check_word("drive after read", '0, data_oe);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d comparisons %0d", error_cnt, tests_run);
    if (error_cnt == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // watchdog well beyond the expected run of a few hundred cycles
  initial begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    void'($urandom(23982));
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys) nrst = 1'b1;
    m = '{default: '0};
    for (int b = 0; b < 4; b++) write_burst(AW'(b * 4), 1'b0);
    for (int i = 0; i < 10; i++) begin
      @(negedge clk_sys) burst_order = 1'($urandom);
      idle(4);
      for (int k = 0; k < 4; k++) m[k] = L'($urandom);
      // a begin with no lane is the abort case, whose burst base is never loaded
      if (&m[0]) m[0][0] = 1'b0;
      if (i == 0) m = '{4'h0, 4'hF, 4'h5, 4'hA};
      write_burst(AW'($urandom), i[0]);
      read_burst(AW'((i % 4) * 4 + $urandom_range(3)));
    end
    // begin write with no lane selected writes nothing
    @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'b0, 1'b0, 1'b0, '1, AW'(5), 1'b0, '0);
    @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'b1, 1'b0, 1'b1, '1, '0, 1'b1, '0);
    idle(1);
    #1 check_bit("drive in abort", 1'b0, |data_oe);
    read_burst(AW'(4));
    @(negedge clk_sys) output_enable_n = 1'b1;
    idle(3);
    read_burst(AW'(8));
    @(negedge clk_sys) output_enable_n = 1'b0;
    u_ctrl_model.doze(1'b1);
    idle(5);
    #1 check_bit("asleep", 1'b1, asleep);
    @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'b0, 1'b0, 1'b0, '0, '0, 1'b0, '0);
    @(negedge clk_sys) u_ctrl_model.put(1'b0, 1'b0, 1'b0, 1'b1, '0, '0, 1'b1, '0);
    @(posedge clk_sys);
    #1 check_bit("drive in sleep", 1'b0, |data_oe);
    u_ctrl_model.doze(1'b0);
    idle(`SLEEP_CYCLES + 4);
    #1 check_bit("awake", 1'b0, asleep);
    read_burst(AW'(0));
    end_of_test();
  end
endmodule
